// >>> dv/tb_top.sv
`timescale 1ns/1ps
`include "umc_regs.vh"
module tb_top;
	reg clk = 0, nrst = 0, wr = 0, rd = 0, rv = 0, cl = 0, hr = 0, rxen = 1;
	reg txen = 0, pend = 0, busy = 0, txd = 1, tick = 0, rf = 0;
	reg [31:0] a = 0, d = 0, m, e;
	reg [3:0] dma = 0;
	reg [2:0] err = 0, se = 0, cnt = 0;
	wire [31:0] rdata;
	wire srx, cmp, irq;
	int mismatches = 0, samples_checked = 0, i;
	logic [31:0] q[$];
	umc_node u_node (.i_clk(clk), .o_rx(srx), .o_cmp(cmp));
	umc_top DUT (.I_CLK(clk), .I_NRST(nrst), .I_ADDR(a), .I_WDATA(d), .I_WR(wr), .I_RD(rd),
		.O_RDATA(rdata), .I_RX_CHAR_LOADED(cl), .I_RX_HOLD_READ(hr), .I_RX_ENABLED(rxen),
		.I_TX_HOLD_PENDING(pend), .I_TX_ENABLED(txen), .I_TX_SHIFT_BUSY(busy),
		.I_OVERRUN_EVT(err[0]), .I_FRAMING_EVT(err[1]), .I_CHECK_BIT_EVT(err[2]),
		.I_RX_DMA_DONE(dma[0]), .I_TX_DMA_DONE(dma[1]), .I_TX_DMA_BUF_EMPTY(dma[2]),
		.I_RX_DMA_BUF_FULL(dma[3]), .I_TX_CORE_DATA(txd), .O_RX_CORE_DATA(),
		.O_RX_SAMPLE_TICK_USED(), .I_RX_SAMPLE_TICK(tick), .I_SERIAL_RX_PIN(srx),
		.I_COMPARATOR_OUT(cmp), .O_SERIAL_TX_PIN(), .I_PLL_SOURCE_CLOCK(cnt[2]),
		.O_MODULATION_CLOCK(), .O_COMPARATOR_THRESHOLD_SELECT(), .O_OPTICAL_ENABLE(),
		.O_CHECK_BIT_KIND(), .O_CHECK_BIT_ENABLE(), .O_CHECK_BIT_FORCED(),
		.O_CHECK_BIT_FORCED_VALUE(), .O_CHECK_BIT_ODD(), .O_CHANNEL_LOOP_SELECT(),
		.O_TX_CORE_ENABLE(), .O_RX_CORE_ENABLE(), .O_IRQ(irq));
	initial forever #2.5 clk = ~clk;
	////////////////////////////////////////////////////////////////
	task chk(input string n, input [31:0] s, input [31:0] x); begin
		samples_checked++;
		if (s !== x) begin
			mismatches++;
			$display("mismatch %s exp %h got %h", n, x, s);
		end
	end endtask
	// One idle cycle after each strobe keeps drivers single per step
	task bus(input w, input [31:0] ad, input [31:0] dt); begin
		a <= ad; d <= dt; wr <= w; rd <= !w;
		@(posedge clk); wr <= 0; rd <= 0;
		@(posedge clk);
	end endtask
	task rdx(input [31:0] ad, input [31:0] x); begin
		q.push_back(x);
		bus(0, ad, 0);
	end endtask
	task irqx(input x); begin
		@(negedge clk) chk("irq", {31'h0, irq}, {31'h0, x});
		@(posedge clk);
	end endtask
	function [31:0] sx;
		sx = {19'h0, dma[3:2], 1'b0, txen & !pend & !busy, 1'b0, se, dma[1:0], 1'b0,
			txen & !pend, rf & rxen};
	endfunction
	task final_report; begin
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	end endtask
	// Read answers stand one cycle only, so they are taken at that edge
	always @(posedge clk) begin
		if (rv) chk("rdata", rdata, q.pop_front());
		rv <= rd;
		tick <= $urandom;
		txd <= $urandom;
		cnt <= cnt + 3'h1;
	end
	initial begin
		#20000 mismatches++;
		final_report;
	end
	initial begin
		void'($urandom(84973));
		repeat (3) @(posedge clk);
		nrst <= 1;
		rdx(`UMC_OFS_MODE, `UMC_MR_RESET);
		rdx(`UMC_OFS_IMR, 0);
		rdx(`UMC_OFS_SR, sx());
		rdx(32'h400E_0700, 0);
		for (i = 0; i < 8; i++) begin
			e = $urandom & 32'h8FFF_31FF | (i % 5) << 28 | i << 9 | (i & 3) << 14;
			bus(1, `UMC_OFS_MODE, e);
			rdx(`UMC_OFS_MODE, e & `UMC_MR_WMASK);
		end
		m = $urandom;
		bus(1, `UMC_OFS_IER, m);
		m = m & `UMC_IRQ_MASK;
		rdx(`UMC_OFS_IMR, m);
		e = $urandom;
		bus(1, `UMC_OFS_IDR, e);
		rdx(`UMC_OFS_IMR, m & ~e);
		bus(1, `UMC_OFS_IDR, 32'hFFFF_FFFF);
		for (i = 0; i < 8; i++) begin
			{dma, txen, pend, busy, rxen} <= $urandom;
			@(posedge clk);
			rdx(`UMC_OFS_SR, sx());
		end
		rxen <= 1; cl <= 1; hr <= 1; err <= 3'h7; // set wins over read
		@(posedge clk);
		cl <= 0; hr <= 0; err <= 0; rf = 1; se = 3'h7;
		rdx(`UMC_OFS_SR, sx());
		rxen <= 0;
		@(posedge clk);
		rdx(`UMC_OFS_SR, sx());
		hr <= 1;
		@(posedge clk);
		hr <= 0; rf = 0; rxen <= 1;
		@(posedge clk);
		rdx(`UMC_OFS_SR, sx());
		bus(1, `UMC_OFS_CTRL, 32'h0000_0100);
		se = 0;
		rdx(`UMC_OFS_SR, sx());
		bus(1, `UMC_OFS_IER, 32'h0000_0020);
		irqx(0);
		err <= 3'h1;
		@(posedge clk);
		err <= 0;
		irqx(1);
		bus(1, `UMC_OFS_CTRL, 32'h0000_0100);
		irqx(0);
		final_report;
	end
endmodule

// >>> dv/umc_node.sv
`timescale 1ns/1ps
module umc_node (
	// Clock and far-side lines
	input wire i_clk,
	output reg o_rx,
	output reg o_cmp
);
	// Remote end changes its lines once per bit time, idle high
	reg [3:0] n_q = 4'h0;
	initial begin
		o_rx = 1;
		o_cmp = 1;
	end
	always @(posedge i_clk) begin
		n_q <= n_q + 4'h1;
		if (n_q == 4'h0) begin
			o_rx <= $urandom;
			o_cmp <= $urandom;
		end
	end
endmodule

// >>> dv/umc_top_monitor.sv
`timescale 1ns/1ps
`include "umc_regs.vh"
module umc_chk (
	// Clock, reset, register port
	input wire I_CLK, input wire I_NRST, input wire [31:0] I_ADDR, input wire I_RD,
	input wire [31:0] O_RDATA,
	// Channel lines
	input wire I_RX_DMA_DONE, input wire I_TX_DMA_DONE,
	input wire I_TX_DMA_BUF_EMPTY, input wire I_RX_DMA_BUF_FULL,
	// Mode decode and pins
	input wire O_SERIAL_TX_PIN, input wire [2:0] O_COMPARATOR_THRESHOLD_SELECT,
	input wire O_OPTICAL_ENABLE, input wire [2:0] O_CHECK_BIT_KIND,
	input wire O_CHECK_BIT_ENABLE, input wire O_CHECK_BIT_FORCED,
	input wire O_CHECK_BIT_FORCED_VALUE, input wire O_CHECK_BIT_ODD,
	input wire [1:0] O_CHANNEL_LOOP_SELECT, input wire O_TX_CORE_ENABLE,
	input wire O_RX_CORE_ENABLE,
	// Serial data paths
	input wire I_TX_CORE_DATA, input wire O_RX_CORE_DATA
);
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_NRST);
	// Read strobes remembered so answers line up with their cause
	reg rd_sr_q = 0, rd_mr_q = 0, rd_im_q = 0;
	reg [3:0] dma_q = 4'h0;
	always @(posedge I_CLK) begin
		rd_sr_q <= I_RD && I_ADDR == `UMC_OFS_SR;
		rd_mr_q <= I_RD && I_ADDR == `UMC_OFS_MODE;
		rd_im_q <= I_RD && I_ADDR == `UMC_OFS_IMR;
		dma_q <= {I_RX_DMA_BUF_FULL, I_TX_DMA_BUF_EMPTY, I_TX_DMA_DONE, I_RX_DMA_DONE};
	end
	////////////////////////////////////////////////////////////////
	property p_dma; rd_sr_q |-> {O_RDATA[12:11], O_RDATA[4:3]} == dma_q; endproperty
	a_dma: assert property (p_dma) else $error("channel flags differ");
	property p_mode;
		rd_mr_q |-> O_RDATA[30:28] == O_COMPARATOR_THRESHOLD_SELECT
			&& O_RDATA[11:9] == O_CHECK_BIT_KIND && O_RDATA[0] == O_OPTICAL_ENABLE
			&& O_RDATA[15:14] == O_CHANNEL_LOOP_SELECT;
	endproperty
	a_mode: assert property (p_mode) else $error("mode outputs differ");
	property p_resv; rd_sr_q || rd_im_q |-> (O_RDATA & ~`UMC_IRQ_MASK) == 0; endproperty
	a_resv: assert property (p_resv) else $error("reserved bit set");
	property p_odd;
		O_CHECK_BIT_KIND == `UMC_PAR_ODD |-> O_CHECK_BIT_ENABLE && O_CHECK_BIT_ODD
			&& !O_CHECK_BIT_FORCED;
	endproperty
	a_odd: assert property (p_odd) else $error("odd decode wrong");
	property p_mark;
		O_CHECK_BIT_KIND == `UMC_PAR_MARK |-> O_CHECK_BIT_FORCED && O_CHECK_BIT_FORCED_VALUE;
	endproperty
	a_mark: assert property (p_mark) else $error("mark decode wrong");
	property p_none; O_CHECK_BIT_KIND == `UMC_PAR_NONE |-> !O_CHECK_BIT_ENABLE; endproperty
	a_none: assert property (p_none) else $error("none decode wrong");
	property p_loop; O_CHANNEL_LOOP_SELECT == `UMC_CHM_LOCAL |=> O_SERIAL_TX_PIN; endproperty
	a_loop: assert property (p_loop) else $error("pin not high in local loop");
	property p_remote;
		O_CHANNEL_LOOP_SELECT == `UMC_CHM_REMOTE |-> !O_TX_CORE_ENABLE && !O_RX_CORE_ENABLE;
	endproperty
	a_remote: assert property (p_remote) else $error("core on in remote loop");
	property p_local_rx;
		O_CHANNEL_LOOP_SELECT == `UMC_CHM_LOCAL |-> O_RX_CORE_DATA == I_TX_CORE_DATA;
	endproperty
	a_local_rx: assert property (p_local_rx) else $error("local loop data lost");
	// Plain electrical mode passes the transmit stream straight to the pin
	property p_plain_tx;
		O_CHANNEL_LOOP_SELECT == `UMC_CHM_NORMAL && !O_OPTICAL_ENABLE
			|=> O_SERIAL_TX_PIN == $past(I_TX_CORE_DATA);
	endproperty
	a_plain_tx: assert property (p_plain_tx) else $error("plain transmit altered");
	c_local: cover property (O_CHANNEL_LOOP_SELECT == `UMC_CHM_LOCAL);
	c_none: cover property (O_CHECK_BIT_KIND == `UMC_PAR_NONE);
	c_sr: cover property (rd_sr_q);
endmodule
bind umc_top umc_chk u_chk (.*);

// >>> hw/umc_regs.vh
`ifndef UMC_REGS_VH
`define UMC_REGS_VH
// Register byte offsets
`define UMC_OFS_MODE 32'h400E_0604
`define UMC_OFS_IER 32'h400E_0608
`define UMC_OFS_IDR 32'h400E_060C
`define UMC_OFS_IMR 32'h400E_0610
`define UMC_OFS_SR 32'h400E_0614
// Control word offset, bit 8 clears error flags
`define UMC_OFS_CTRL 32'h400E_0600
`define UMC_CTRL_CLR_ERR 8
// Mode field positions
`define UMC_MR_OPTICAL_ENABLE 0
`define UMC_MR_RXINV 1
`define UMC_MR_MDINV 2
`define UMC_MR_FILTER 4
`define UMC_MR_PAR_LO 9
`define UMC_MR_PAR_HI 11
`define UMC_MR_CHM_LO 14
`define UMC_MR_CHM_HI 15
`define UMC_MR_DIV_LO 16
`define UMC_MR_DIV_HI 20
`define UMC_MR_DUTY_LO 24
`define UMC_MR_DUTY_HI 26
`define UMC_MR_CMP_LO 28
`define UMC_MR_CMP_HI 30
`define UMC_MR_RESET 32'h0013_0000
`define UMC_MR_WMASK 32'h771F_CE17
// Status bits
`define UMC_SR_RX_CHAR_AVAILABLE 0
`define UMC_SR_TX_HOLDING_FREE 1
`define UMC_SR_RX_DMA_TRANSFER_DONE 3
`define UMC_SR_TX_DMA_TRANSFER_DONE 4
`define UMC_SR_OVERRUN_FLAG 5
`define UMC_SR_FRAME 6
`define UMC_SR_CHECK_BIT_ERROR_FLAG 7
`define UMC_SR_TX_ALL_IDLE 9
`define UMC_SR_TX_DMA_BUFFER_EMPTY 11
`define UMC_SR_RX_DMA_BUFFER_FULL 12
`define UMC_IRQ_MASK 32'h0000_1AFB
// Channel modes
`define UMC_CHM_NORMAL 2'h0
`define UMC_CHM_ECHO 2'h1
`define UMC_CHM_LOCAL 2'h2
`define UMC_CHM_REMOTE 2'h3
// Check bit kinds
`define UMC_PAR_EVEN 3'h0
`define UMC_PAR_ODD 3'h1
`define UMC_PAR_SPACE 3'h2
`define UMC_PAR_MARK 3'h3
`define UMC_PAR_NONE 3'h4
// Modulation divider terms
`define UMC_DIV_OFFSET 6'h08
`define UMC_DIV_SHIFT 3
`define UMC_DUTY_STEPS 7'h10
`endif

// >>> hw/umc_top.v
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "umc_regs.vh"
// How it works
// - Optical enable inverts transmit data before modulator
// - Receive invert flips comparator output
// - Modulator invert flips transmit pin drive in normal channel mode when optical enable is set
// - Filter enables two-of-three majority at 16x
// - Check bit field decodes even/odd/low/high/none
// - Modulation period is 8*(divider+8) PLL clocks
// - Duty code lowers high time by sixteenths
// - Threshold code forwarded to comparator
// - Enable write sets mask bits written one
// - Disable write clears mask bits written one
// - Mask read shows enabled sources
// - Receive available set on unread character
// - Receive available zero after read or disabled
// - Holding free zero when pending or disabled
// - DMA done flags mirror channel signals
// - Overrun sticky until error clear
// - Framing error sticky until error clear
// - Check bit error sticky until error clear
// - Error clear command clears three error flags
// - All idle only when holding and shifter empty
// - Local loop feeds transmitter to receiver
// - Echo and remote loop send receive to pin
module umc_top #(
	parameter DIV_W = 5
) (
	// Clock and reset
	input wire I_CLK,
	input wire I_NRST,
	// Register port
	input wire [31:0] I_ADDR,
	input wire [31:0] I_WDATA,
	input wire I_WR,
	input wire I_RD,
	output reg [31:0] O_RDATA,
	// Receiver and transmitter core status
	input wire I_RX_CHAR_LOADED,
	input wire I_RX_HOLD_READ,
	input wire I_RX_ENABLED,
	input wire I_TX_HOLD_PENDING,
	input wire I_TX_ENABLED,
	input wire I_TX_SHIFT_BUSY,
	input wire I_OVERRUN_EVT,
	input wire I_FRAMING_EVT,
	input wire I_CHECK_BIT_EVT,
	// DMA channel signals
	input wire I_RX_DMA_DONE,
	input wire I_TX_DMA_DONE,
	input wire I_TX_DMA_BUF_EMPTY,
	input wire I_RX_DMA_BUF_FULL,
	// Serial data paths
	input wire I_TX_CORE_DATA,
	output wire O_RX_CORE_DATA,
	output wire O_RX_SAMPLE_TICK_USED,
	input wire I_RX_SAMPLE_TICK,
	input wire I_SERIAL_RX_PIN,
	input wire I_COMPARATOR_OUT,
	output reg O_SERIAL_TX_PIN,
	// Optical link
	input wire I_PLL_SOURCE_CLOCK,
	output reg O_MODULATION_CLOCK,
	output wire [2:0] O_COMPARATOR_THRESHOLD_SELECT,
	output wire O_OPTICAL_ENABLE,
	// Mode decode
	output wire [2:0] O_CHECK_BIT_KIND,
	output wire O_CHECK_BIT_ENABLE,
	output wire O_CHECK_BIT_FORCED,
	output wire O_CHECK_BIT_FORCED_VALUE,
	output wire O_CHECK_BIT_ODD,
	output wire [1:0] O_CHANNEL_LOOP_SELECT,
	output wire O_TX_CORE_ENABLE,
	output wire O_RX_CORE_ENABLE,
	// Interrupt request
	output wire O_IRQ
);
	////////////////////////////////////////////////////////////////////////////////
	// Register port
	reg [31:0] mode_q;
	reg [31:0] mask_q;
	reg overrun_flag_q;
	reg frame_q;
	reg check_bit_error_flag_q;
	reg rx_char_available_q;
	wire [31:0] status;
	wire wr_mode = I_WR && (I_ADDR == `UMC_OFS_MODE);
	wire wr_ier = I_WR && (I_ADDR == `UMC_OFS_IER);
	wire wr_idr = I_WR && (I_ADDR == `UMC_OFS_IDR);
	wire clr_err = I_WR && (I_ADDR == `UMC_OFS_CTRL) && I_WDATA[`UMC_CTRL_CLR_ERR];

	always @(posedge I_CLK) begin
		if (!I_NRST) begin
			mode_q <= `UMC_MR_RESET;
			mask_q <= 32'h0000_0000;
		end else begin
			if (wr_mode) begin
				mode_q <= I_WDATA & `UMC_MR_WMASK;
			end
			if (wr_ier) begin
				mask_q <= mask_q | (I_WDATA & `UMC_IRQ_MASK);
			end else if (wr_idr) begin
				mask_q <= mask_q & ~(I_WDATA & `UMC_IRQ_MASK);
			end
		end
	end

	// Unmapped and write-only addresses read as zero
	always @(posedge I_CLK) begin
		if (!I_NRST) begin
			O_RDATA <= 32'h0000_0000;
		end else if (I_RD) begin
			case (I_ADDR)
				`UMC_OFS_MODE: O_RDATA <= mode_q;
				`UMC_OFS_IMR: O_RDATA <= mask_q;
				`UMC_OFS_SR: O_RDATA <= status;
				default: O_RDATA <= 32'h0000_0000;
			endcase
		end else begin
			O_RDATA <= 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Status flags; set wins over clear, except receive disable, which clears receive available
	always @(posedge I_CLK) begin
		if (!I_NRST) begin
			overrun_flag_q <= 1'b0;
			frame_q <= 1'b0;
			check_bit_error_flag_q <= 1'b0;
			rx_char_available_q <= 1'b0;
		end else begin
			overrun_flag_q <= I_OVERRUN_EVT | (overrun_flag_q & ~clr_err);
			frame_q <= I_FRAMING_EVT | (frame_q & ~clr_err);
			check_bit_error_flag_q <= I_CHECK_BIT_EVT | (check_bit_error_flag_q & ~clr_err);
			if (!I_RX_ENABLED) begin
				rx_char_available_q <= 1'b0;
			end else begin
				rx_char_available_q <= I_RX_CHAR_LOADED | (rx_char_available_q & ~I_RX_HOLD_READ);
			end
		end
	end

	wire tx_holding_free = I_TX_ENABLED & ~I_TX_HOLD_PENDING;
	wire tx_all_idle = I_TX_ENABLED & ~I_TX_HOLD_PENDING & ~I_TX_SHIFT_BUSY;

	assign status = {19'h0_0000, I_RX_DMA_BUF_FULL, I_TX_DMA_BUF_EMPTY, 1'b0, tx_all_idle, 1'b0,
		check_bit_error_flag_q, frame_q, overrun_flag_q, I_TX_DMA_DONE, I_RX_DMA_DONE, 1'b0, tx_holding_free, rx_char_available_q};

	assign O_IRQ = |(status & mask_q);

	////////////////////////////////////////////////////////////////////////////////
	// Mode decode
	wire optical_enable = mode_q[`UMC_MR_OPTICAL_ENABLE];
	wire rx_inv = mode_q[`UMC_MR_RXINV];
	wire md_inv = mode_q[`UMC_MR_MDINV];
	wire filt_en = mode_q[`UMC_MR_FILTER];
	wire [2:0] par = mode_q[`UMC_MR_PAR_HI:`UMC_MR_PAR_LO];
	wire [1:0] chm = mode_q[`UMC_MR_CHM_HI:`UMC_MR_CHM_LO];
	wire [DIV_W-1:0] div_sel = mode_q[`UMC_MR_DIV_HI:`UMC_MR_DIV_LO];
	wire [2:0] duty = mode_q[`UMC_MR_DUTY_HI:`UMC_MR_DUTY_LO];

	assign O_CHECK_BIT_KIND = par;
	assign O_CHECK_BIT_ENABLE = (par <= `UMC_PAR_MARK);
	assign O_CHECK_BIT_FORCED = (par == `UMC_PAR_SPACE) | (par == `UMC_PAR_MARK);
	assign O_CHECK_BIT_FORCED_VALUE = (par == `UMC_PAR_MARK);
	assign O_CHECK_BIT_ODD = (par == `UMC_PAR_ODD);
	assign O_CHANNEL_LOOP_SELECT = chm;
	assign O_TX_CORE_ENABLE = (chm != `UMC_CHM_REMOTE);
	assign O_RX_CORE_ENABLE = (chm != `UMC_CHM_REMOTE);
	assign O_COMPARATOR_THRESHOLD_SELECT = mode_q[`UMC_MR_CMP_HI:`UMC_MR_CMP_LO];
	assign O_OPTICAL_ENABLE = optical_enable;

	////////////////////////////////////////////////////////////////////////////////
	// Receive line: three-stage synchroniser, then optional majority
	reg [2:0] pin_sync_q;
	reg [2:0] cmp_sync_q;
	reg pin_lvl_q;
	reg cmp_lvl_q;
	reg [2:0] maj_q;
	always @(posedge I_CLK) begin
		if (!I_NRST) begin
			pin_sync_q <= 3'h7;
			cmp_sync_q <= 3'h7;
			pin_lvl_q <= 1'b1;
			cmp_lvl_q <= 1'b1;
		end else begin
			pin_sync_q <= {pin_sync_q[1:0], I_SERIAL_RX_PIN};
			cmp_sync_q <= {cmp_sync_q[1:0], I_COMPARATOR_OUT};
			// Only accept a level once the two later stages agree
			if (pin_sync_q[1] == pin_sync_q[2]) begin
				pin_lvl_q <= pin_sync_q[2];
			end
			if (cmp_sync_q[1] == cmp_sync_q[2]) begin
				cmp_lvl_q <= cmp_sync_q[2];
			end
		end
	end

	wire cmp_data = cmp_lvl_q ^ rx_inv;
	wire line_in = optical_enable ? cmp_data : pin_lvl_q;

	// Samples are taken on the 16x tick from the baud generator
	always @(posedge I_CLK) begin
		if (!I_NRST) begin
			maj_q <= 3'h7;
		end else if (I_RX_SAMPLE_TICK) begin
			maj_q <= {maj_q[1:0], line_in};
		end
	end
	wire maj = (maj_q[0] & maj_q[1]) | (maj_q[1] & maj_q[2]) | (maj_q[0] & maj_q[2]);
	wire rx_line = filt_en ? maj : line_in;
	assign O_RX_SAMPLE_TICK_USED = filt_en;

	wire tx_stream = optical_enable ? ~I_TX_CORE_DATA : I_TX_CORE_DATA;
	assign O_RX_CORE_DATA = (chm == `UMC_CHM_LOCAL) ? I_TX_CORE_DATA : rx_line;

	////////////////////////////////////////////////////////////////////////////////
	// Modulation clock; PLL clock is sampled, so it must be well below I_CLK
	reg [2:0] pll_sync_q;
	reg [8:0] mod_cnt_q;
	wire pll_rise = pll_sync_q[1] & ~pll_sync_q[2];
	// Period 8*(div+8); high time = period*(8-duty)/16
	wire [8:0] period = {({1'b0, div_sel} + `UMC_DIV_OFFSET), 3'b000};
	wire [3:0] duty_num = 4'h8 - {1'b0, duty};
	wire [12:0] hi_prod = period * duty_num;
	wire [8:0] hi_time = hi_prod[12:4];
	always @(posedge I_CLK) begin
		if (!I_NRST) begin
			pll_sync_q <= 3'h0;
			mod_cnt_q <= 9'h000;
			O_MODULATION_CLOCK <= 1'b0;
		end else begin
			pll_sync_q <= {pll_sync_q[1:0], I_PLL_SOURCE_CLOCK};
			if (pll_rise) begin
				if (mod_cnt_q >= period - 9'h001) begin
					mod_cnt_q <= 9'h000;
				end else begin
					mod_cnt_q <= mod_cnt_q + 9'h001;
				end
				O_MODULATION_CLOCK <= (mod_cnt_q < hi_time);
			end
		end
	end

	// Logical 1 modulates, logical 0 idles high
	wire mod_data = optical_enable ? (tx_stream | O_MODULATION_CLOCK) : tx_stream;
	wire mod_out = optical_enable ? (mod_data ^ md_inv) : mod_data;

	////////////////////////////////////////////////////////////////////////////////
	// Transmit pin by channel mode
	always @(posedge I_CLK) begin
		if (!I_NRST) begin
			O_SERIAL_TX_PIN <= 1'b1;
		end else begin
			case (chm)
				`UMC_CHM_NORMAL: O_SERIAL_TX_PIN <= mod_out;
				`UMC_CHM_ECHO: O_SERIAL_TX_PIN <= rx_line;
				`UMC_CHM_LOCAL: O_SERIAL_TX_PIN <= 1'b1;
				`UMC_CHM_REMOTE: O_SERIAL_TX_PIN <= rx_line;
				default: O_SERIAL_TX_PIN <= 1'b1;
			endcase
		end
	end
endmodule
